/* src/mis_consts.svh */
// Constants for the interrupt sequencer: offsets, fields, vectors, AXI responses.
// Included by package users; holds definitions only.
`ifndef MIS_CONSTS_SVH
`define MIS_CONSTS_SVH
// Register byte offsets on the AXI4-Lite slave
`define MIS_OFF_CTRL      8'h00
`define MIS_OFF_TCR       8'h04
`define MIS_OFF_SCR2      8'h08
`define MIS_OFF_STATUS    8'h0c
`define MIS_OFF_WDOG      8'h10
`define MIS_OFF_VECTOR    8'h14
// Control register fields
`define MIS_CTRL_IMASK    0
// Timer control field width (enables) and serial enable width
`define MIS_TMR_BITS      3
`define MIS_SCI_BITS      5
// Watchdog control: failure flag position
`define MIS_WDOG_FAIL     4
// Vector locations, even address holds the high byte
`define MIS_VEC_RESET     16'h3ffe
`define MIS_VEC_SWI       16'h3ffc
`define MIS_VEC_EXT       16'h3ffa
`define MIS_VEC_TMR       16'h3ff8
`define MIS_VEC_SCI       16'h3ff6
// AXI responses
`define MIS_RESP_OKAY     2'h0
`define MIS_RESP_SLVERR   2'h2
`endif

/* src/mis_pkg.sv */
// Types of the interrupt sequencer.
// Assumes the constants header is on the include path.
package mis_pkg;
    typedef enum logic [2:0] {
        MIS_RUN    = 3'b000,
        MIS_STACK  = 3'b001,
        MIS_VEC_HI = 3'b010,
        MIS_VEC_LO = 3'b011,
        MIS_WAIT   = 3'b100,
        MIS_STOP   = 3'b101
    } mis_state_t;

    typedef enum logic [2:0] {
        MIS_SRC_NONE  = 3'b000,
        MIS_SRC_RESET = 3'b001,
        MIS_SRC_SWI   = 3'b010,
        MIS_SRC_EXT   = 3'b011,
        MIS_SRC_TMR   = 3'b100,
        MIS_SRC_SCI   = 3'b101
    } mis_src_t;

    // Instruction-boundary events from the core
    typedef struct packed {
        logic done;   // instruction completed
        logic software_interrupt_instruction;    // software interrupt fetched
        logic return_from_interrupt;    // return from interrupt executed
        logic wait_i; // wait instruction executed
        logic stop;   // stop instruction executed
    } mis_core_ev_t;

    // Vector fetch request to memory
    typedef struct packed {
        logic        valid;
        logic [15:0] addr;
    } mis_fetch_t;
endpackage

/* src/mis_seq.sv */
// Interrupt arbitration and sequencing for a small 8-bit core.
// Assumes core events arrive as single-cycle pulses on MCLK_I and
// software reaches the registers over AXI4-Lite.
//
// The implementer's own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`include "mis_consts.svh"
module mis_seq
    import mis_pkg::*;
(
    input  wire logic        MCLK_I,
    input  wire logic        RSTN_I,
    input  wire logic        EXT_IRQ_I,      // pin request, active high
    input  wire logic        EXT_LEVEL_I,    // 1 = level sensitive, 0 = edge
    input  wire logic [2:0]  TMR_FLAGS_I,    // capture, compare, overflow
    input  wire logic [4:0]  SCI_FLAGS_I,    // tx empty, tx done, rx full, idle, overrun
    input  wire logic        WDOG_RST_EV_I,  // watchdog or clock monitor reset seen
    input  wire mis_core_ev_t CORE_EV_I,
    input  wire logic        STACK_DONE_I,   // core finished push or pull
    input  wire logic [7:0]  VEC_DATA_I,     // byte returned for vector fetch
    input  wire logic        VEC_ACK_I,      // byte valid
    output mis_fetch_t       FETCH_O,
    output logic             STACK_PUSH_O,
    output logic             STACK_PULL_O,
    output logic [15:0]      PC_LOAD_O,
    output logic             PC_LOAD_VALID_O,
    output logic             CPU_CLK_EN_O,
    output logic             OSC_EN_O,
    output logic             IMASK_O,
    // AXI4-Lite slave
    input  wire logic [7:0]  S_AXI_AWADDR,
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    output logic [1:0]       S_AXI_BRESP,
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    input  wire logic [7:0]  S_AXI_ARADDR,
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    output logic [31:0]      S_AXI_RDATA,
    output logic [1:0]       S_AXI_RRESP,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY
);
    mis_state_t  state_reg;
    mis_src_t    src_reg;
    logic        imask_reg;
    logic [2:0]  tmr_en_reg;
    logic [4:0]  sci_en_reg;
    logic        ext_latch_reg;
    logic        ext_prev_reg;
    logic        wdog_fail_reg;
    logic        swi_pend_reg;
    logic        reset_vec_reg;
    logic [15:0] vec_addr_reg;
    logic [7:0]  vec_hi_reg;
    logic        ext_sync;
    logic        ext_req;
    logic        tmr_req;
    logic        sci_req;
    mis_src_t    pick;
    logic        aw_held_reg;
    logic        w_held_reg;
    logic [7:0]  aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0]  w_strb_reg;
    logic        wr_fire;
    logic        rd_fire;
    logic        wr_imask;
    logic        wr_tcr;
    logic        wr_scr;
    logic        wdog_read;

    // Pin synchronised before any edge logic
    mis_sync u_ext_sync (
        .clk_i   (MCLK_I),
        .rst_n_i (RSTN_I),
        .d_i     (EXT_IRQ_I),
        .q_o     (ext_sync)
    );

    // Pending request terms
    assign ext_req = ext_latch_reg;
    assign tmr_req = |(TMR_FLAGS_I & tmr_en_reg);
    assign sci_req = |(SCI_FLAGS_I & sci_en_reg);

    // Fixed priority; software pending from earlier fetch goes first
    always_comb begin
        pick = MIS_SRC_NONE;
        if (reset_vec_reg) begin
            pick = MIS_SRC_RESET;
        end else if (swi_pend_reg) begin
            pick = MIS_SRC_SWI;
        end else if (!imask_reg && ext_req) begin
            pick = MIS_SRC_EXT;
        end else if (!imask_reg && tmr_req) begin
            pick = MIS_SRC_TMR;
        end else if (!imask_reg && sci_req) begin
            pick = MIS_SRC_SCI;
        end
    end

    // Write channel handshakes: address and data taken in either order
    assign wr_fire   = aw_held_reg && w_held_reg && !S_AXI_BVALID;
    assign rd_fire   = S_AXI_ARVALID && S_AXI_ARREADY;
    assign wr_imask  = wr_fire && aw_addr_reg == `MIS_OFF_CTRL && w_strb_reg[0];
    assign wr_tcr    = wr_fire && aw_addr_reg == `MIS_OFF_TCR && w_strb_reg[0];
    assign wr_scr    = wr_fire && aw_addr_reg == `MIS_OFF_SCR2 && w_strb_reg[0];
    assign wdog_read = rd_fire && S_AXI_ARADDR == `MIS_OFF_WDOG;

    // Sequencer: boundary check, stacking, two-byte vector fetch, sleep
    always_ff @(posedge MCLK_I) begin
        if (!RSTN_I) begin
            state_reg     <= MIS_VEC_HI;
            src_reg       <= MIS_SRC_RESET;
            vec_addr_reg  <= `MIS_VEC_RESET;
        end else begin
            unique case (state_reg)
                MIS_RUN: begin
                    if (CORE_EV_I.stop) begin
                        state_reg <= MIS_STOP;
                    end else if (CORE_EV_I.wait_i) begin
                        state_reg <= MIS_WAIT;
                    end else if (CORE_EV_I.done && pick != MIS_SRC_NONE) begin
                        src_reg   <= pick;
                        state_reg <= MIS_STACK;
                    end
                end
                MIS_STACK: begin
                    if (STACK_DONE_I) begin
                        state_reg <= MIS_VEC_HI;
                        unique case (src_reg)
                            MIS_SRC_SWI: vec_addr_reg <= `MIS_VEC_SWI;
                            MIS_SRC_EXT: vec_addr_reg <= `MIS_VEC_EXT;
                            MIS_SRC_TMR: vec_addr_reg <= `MIS_VEC_TMR;
                            MIS_SRC_SCI: vec_addr_reg <= `MIS_VEC_SCI;
                            default:     vec_addr_reg <= `MIS_VEC_RESET;
                        endcase
                    end
                end
                MIS_VEC_HI: begin
                    if (VEC_ACK_I) begin
                        state_reg    <= MIS_VEC_LO;
                        vec_addr_reg <= vec_addr_reg | 16'h0001;
                    end
                end
                MIS_VEC_LO: begin
                    if (VEC_ACK_I) begin
                        state_reg <= MIS_RUN;
                    end
                end
                MIS_WAIT: begin
                    // Same sources, normal vectors, no wait vectors
                    if (pick != MIS_SRC_NONE) begin
                        src_reg   <= pick;
                        state_reg <= MIS_STACK;
                    end
                end
                MIS_STOP: begin
                    if (!imask_reg && ext_req) begin
                        src_reg   <= MIS_SRC_EXT;
                        state_reg <= MIS_STACK;
                    end
                end
                default: state_reg <= MIS_RUN;
            endcase
        end
    end

    // Vector high byte captured, PC loaded once the low byte lands
    always_ff @(posedge MCLK_I) begin
        if (!RSTN_I) begin
            vec_hi_reg      <= 8'h00;
            PC_LOAD_O       <= 16'h0000;
            PC_LOAD_VALID_O <= 1'b0;
        end else begin
            PC_LOAD_VALID_O <= 1'b0;
            if (state_reg == MIS_VEC_HI && VEC_ACK_I) begin
                vec_hi_reg <= VEC_DATA_I;
            end
            if (state_reg == MIS_VEC_LO && VEC_ACK_I) begin
                PC_LOAD_O       <= {vec_hi_reg, VEC_DATA_I};
                PC_LOAD_VALID_O <= 1'b1;
            end
        end
    end

    // Core-facing strobes, all registered
    always_ff @(posedge MCLK_I) begin
        if (!RSTN_I) begin
            FETCH_O      <= '0;
            STACK_PUSH_O <= 1'b0;
            STACK_PULL_O <= 1'b0;
            CPU_CLK_EN_O <= 1'b1;
            OSC_EN_O     <= 1'b1;
        end else begin
            FETCH_O.valid <= (state_reg == MIS_VEC_HI || state_reg == MIS_VEC_LO)
                             && !VEC_ACK_I;
            FETCH_O.addr  <= vec_addr_reg;
            STACK_PUSH_O  <= state_reg == MIS_STACK;
            STACK_PULL_O  <= state_reg == MIS_RUN && CORE_EV_I.return_from_interrupt;
            CPU_CLK_EN_O  <= state_reg != MIS_WAIT && state_reg != MIS_STOP;
            OSC_EN_O      <= state_reg != MIS_STOP;
        end
    end

    // Global mask: set by reset and on entry, cleared by stop, wait, software
    always_ff @(posedge MCLK_I) begin
        if (!RSTN_I) begin
            imask_reg <= 1'b1;
        end else if (state_reg == MIS_STACK && STACK_DONE_I) begin
            imask_reg <= 1'b1;
        end else if (state_reg == MIS_RUN && (CORE_EV_I.stop || CORE_EV_I.wait_i)) begin
            imask_reg <= 1'b0;
        end else if (wr_imask) begin
            imask_reg <= w_data_reg[`MIS_CTRL_IMASK];
        end
    end
    assign IMASK_O = imask_reg;

    // Peripheral enables; stop entry wipes them
    always_ff @(posedge MCLK_I) begin
        if (!RSTN_I) begin
            tmr_en_reg <= 3'h0;
            sci_en_reg <= 5'h00;
        end else if (state_reg == MIS_RUN && CORE_EV_I.stop) begin
            tmr_en_reg <= 3'h0;
            sci_en_reg <= 5'h00;
        end else begin
            if (wr_tcr) tmr_en_reg <= w_data_reg[2:0];
            if (wr_scr) sci_en_reg <= w_data_reg[4:0];
        end
    end

    // Pin latch: set wins over the early clear in service
    always_ff @(posedge MCLK_I) begin
        if (!RSTN_I) begin
            ext_prev_reg  <= 1'b0;
            ext_latch_reg <= 1'b0;
        end else begin
            ext_prev_reg <= ext_sync;
            if (EXT_LEVEL_I ? ext_sync : (ext_sync && !ext_prev_reg)) begin
                ext_latch_reg <= 1'b1;
            end else if (state_reg == MIS_STACK && src_reg == MIS_SRC_EXT) begin
                ext_latch_reg <= 1'b0;
            end
        end
    end

    // Software interrupt pending and reset vector flag
    always_ff @(posedge MCLK_I) begin
        if (!RSTN_I) begin
            swi_pend_reg  <= 1'b0;
            reset_vec_reg <= 1'b0;
        end else begin
            if (CORE_EV_I.software_interrupt_instruction) begin
                swi_pend_reg <= 1'b1;
            end else if (state_reg == MIS_STACK && src_reg == MIS_SRC_SWI) begin
                swi_pend_reg <= 1'b0;
            end
            reset_vec_reg <= 1'b0;
        end
    end

    // Watchdog failure flag: event wins over read clear
    always_ff @(posedge MCLK_I) begin
        if (!RSTN_I) begin
            wdog_fail_reg <= 1'b0;
        end else if (WDOG_RST_EV_I) begin
            wdog_fail_reg <= 1'b1;
        end else if (wdog_read) begin
            wdog_fail_reg <= 1'b0;
        end
    end

    // AXI write side: hold each channel until both are in
    always_ff @(posedge MCLK_I) begin
        if (!RSTN_I) begin
            aw_held_reg   <= 1'b0;
            w_held_reg    <= 1'b0;
            aw_addr_reg   <= 8'h00;
            w_data_reg    <= 32'h0;
            w_strb_reg    <= 4'h0;
            S_AXI_AWREADY <= 1'b1;
            S_AXI_WREADY  <= 1'b1;
            S_AXI_BVALID  <= 1'b0;
            S_AXI_BRESP   <= `MIS_RESP_OKAY;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_held_reg   <= 1'b1;
                aw_addr_reg   <= S_AXI_AWADDR;
                S_AXI_AWREADY <= 1'b0;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_held_reg   <= 1'b1;
                w_data_reg   <= S_AXI_WDATA;
                w_strb_reg   <= S_AXI_WSTRB;
                S_AXI_WREADY <= 1'b0;
            end
            if (wr_fire) begin
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP  <= (aw_addr_reg == `MIS_OFF_CTRL ||
                                 aw_addr_reg == `MIS_OFF_TCR  ||
                                 aw_addr_reg == `MIS_OFF_SCR2) ?
                                `MIS_RESP_OKAY : `MIS_RESP_SLVERR;
            end
            if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID  <= 1'b0;
                aw_held_reg   <= 1'b0;
                w_held_reg    <= 1'b0;
                S_AXI_AWREADY <= 1'b1;
                S_AXI_WREADY  <= 1'b1;
            end
        end
    end

    // AXI read side: one read at a time, status shows live state
    always_ff @(posedge MCLK_I) begin
        if (!RSTN_I) begin
            S_AXI_ARREADY <= 1'b1;
            S_AXI_RVALID  <= 1'b0;
            S_AXI_RDATA   <= 32'h0;
            S_AXI_RRESP   <= `MIS_RESP_OKAY;
        end else if (rd_fire) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID  <= 1'b1;
            S_AXI_RRESP   <= `MIS_RESP_OKAY;
            unique case (S_AXI_ARADDR)
                `MIS_OFF_CTRL:   S_AXI_RDATA <= {31'h0, imask_reg};
                `MIS_OFF_TCR:    S_AXI_RDATA <= {29'h0, tmr_en_reg};
                `MIS_OFF_SCR2:   S_AXI_RDATA <= {27'h0, sci_en_reg};
                `MIS_OFF_STATUS: S_AXI_RDATA <= {20'h0, swi_pend_reg, ext_latch_reg,
                                                 sci_req, tmr_req, 1'b0,
                                                 src_reg, 1'b0, state_reg};
                `MIS_OFF_WDOG:   S_AXI_RDATA <= {27'h0, wdog_fail_reg, 4'h0};
                `MIS_OFF_VECTOR: S_AXI_RDATA <= {16'h0, PC_LOAD_O};
                default: begin
                    S_AXI_RDATA <= 32'h0;
                    S_AXI_RRESP <= `MIS_RESP_SLVERR;
                end
            endcase
        end else if (S_AXI_RVALID && S_AXI_RREADY) begin
            S_AXI_RVALID  <= 1'b0;
            S_AXI_ARREADY <= 1'b1;
        end
    end
endmodule // mis_seq

/* src/mis_sync.sv */
// Two-flop synchroniser for one level.
// Assumes a single clock and synchronous active-low reset.
`timescale 1ns/1ps
module mis_sync (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic d_i,
    output logic      q_o
);
    logic meta_reg;
    // First flop is read only by the second
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            meta_reg <= 1'b0;
            q_o      <= 1'b0;
        end else begin
            meta_reg <= d_i;
            q_o      <= meta_reg;
        end
    end
endmodule // mis_sync

/* testbench/mis_core_model.sv */
// Core and vector memory model facing the sequencer.
// Assumes the sequencer clock; slow_i adds three cycles to each answer.
`timescale 1ns/1ps
module mis_core_model
    import mis_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       slow_i,
    input  wire mis_fetch_t fetch_i,
    input  wire logic       push_i,
    input  wire logic       pull_i,
    output logic            done_o,
    output logic [7:0]      data_o,
    output logic            ack_o
);
    logic [2:0]  wait_reg;
    logic        pushed_reg;
    logic        pull_reg;
    logic        served_reg;
    logic [15:0] addr_reg;
    // Served flags stop a held request from being answered twice
    wire want_stk = (push_i && !pushed_reg) || pull_reg;
    wire want_vec = fetch_i.valid && !(served_reg && addr_reg == fetch_i.addr);
    wire go       = wait_reg >= (slow_i ? 3'h3 : 3'h0);

    // Answers stacking, then each vector byte; data line churns when idle
    always_ff @(posedge clk_i) begin
        done_o <= 1'b0;
        ack_o <= 1'b0;
        data_o <= ~data_o;
        if (!rst_n_i) begin
            {wait_reg, pushed_reg, pull_reg, served_reg, addr_reg, data_o} <= '0;
        end else begin
            if (pull_i) pull_reg <= 1'b1;
            if (!push_i) pushed_reg <= 1'b0;
            if (!fetch_i.valid) served_reg <= 1'b0;
            wait_reg <= (want_stk || want_vec) ? wait_reg + 3'h1 : 3'h0;
            if (want_stk && go) begin // Registers pushed or pulled
                done_o <= 1'b1;
                pushed_reg <= push_i;
                pull_reg <= 1'b0;
                wait_reg <= 3'h0;
            end else if (want_vec && go) begin // Byte per location
                ack_o <= 1'b1;
                data_o <= fetch_i.addr[7:0] ^ 8'h5a;
                served_reg <= 1'b1;
                addr_reg <= fetch_i.addr;
                wait_reg <= 3'h0;
            end
        end
    end
endmodule // mis_core_model

/* testbench/mis_seq_monitor.sv */
// Concurrent checks on the interrupt sequencer ports.
// Assumes one clock domain, synchronous active-low reset; bound below.
`timescale 1ns/1ps
module mis_seq_monitor
    import mis_pkg::*;
(
    input wire logic         MCLK_I,
    input wire logic         RSTN_I,
    input wire mis_core_ev_t CORE_EV_I,
    input wire logic         STACK_DONE_I,
    input wire logic         VEC_ACK_I,
    input wire mis_fetch_t   FETCH_O,
    input wire logic         STACK_PUSH_O,
    input wire logic         STACK_PULL_O,
    input wire logic         PC_LOAD_VALID_O,
    input wire logic         CPU_CLK_EN_O,
    input wire logic         OSC_EN_O,
    input wire logic         IMASK_O
);
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (!RSTN_I);

    // Entry, fetch and sleep relations
    property p_mask_reset; $rose(RSTN_I) |-> IMASK_O; endproperty
    property p_push_hold; STACK_PUSH_O && !$past(STACK_DONE_I) |=> STACK_PUSH_O; endproperty
    property p_mask_entry; STACK_PUSH_O && STACK_DONE_I |=> IMASK_O ##1 !STACK_PUSH_O; endproperty
    property p_hi_lo;
        FETCH_O.valid && !FETCH_O.addr[0] && VEC_ACK_I
            |=> ##1 FETCH_O.valid && FETCH_O.addr == ($past(FETCH_O.addr, 2) | 16'h0001);
    endproperty
    property p_pc_load;
        FETCH_O.valid && FETCH_O.addr[0] && VEC_ACK_I |=> PC_LOAD_VALID_O ##1 !PC_LOAD_VALID_O;
    endproperty
    property p_vec_range; FETCH_O.valid |-> FETCH_O.addr inside {[16'h3ff6:16'h3fff]}; endproperty
    property p_rti; CORE_EV_I.return_from_interrupt |-> ##[1:2] STACK_PULL_O; endproperty
    property p_stop; CORE_EV_I.stop |=> !IMASK_O ##1 !OSC_EN_O && !CPU_CLK_EN_O; endproperty
    property p_wait; CORE_EV_I.wait_i |=> !IMASK_O ##1 !CPU_CLK_EN_O && OSC_EN_O; endproperty
    property p_asleep;
        !OSC_EN_O |-> !FETCH_O.valid && !PC_LOAD_VALID_O && !STACK_PUSH_O;
    endproperty

    a_mask_reset: assert property (p_mask_reset) else $error("mask clear after reset");
    a_push_hold: assert property (p_push_hold) else $error("stacking dropped early");
    a_mask_entry: assert property (p_mask_entry) else $error("mask not set at entry");
    a_hi_lo: assert property (p_hi_lo) else $error("low byte not next");
    a_pc_load: assert property (p_pc_load) else $error("pc load not one cycle");
    a_vec_range: assert property (p_vec_range) else $error("fetch outside vectors");
    a_rti: assert property (p_rti) else $error("no pull after return");
    a_stop: assert property (p_stop) else $error("stop entry wrong");
    a_wait: assert property (p_wait) else $error("wait entry wrong");
    a_asleep: assert property (p_asleep) else $error("activity while stopped");

    // Main scenarios reached
    c_stop: cover property (CORE_EV_I.stop);
    c_wait: cover property (CORE_EV_I.wait_i);
    c_swi: cover property (CORE_EV_I.software_interrupt_instruction ##[1:40] PC_LOAD_VALID_O);
endmodule // mis_seq_monitor

bind mis_seq mis_seq_monitor u_mon (.MCLK_I(MCLK_I), .RSTN_I(RSTN_I), .CORE_EV_I(CORE_EV_I),
    .STACK_DONE_I(STACK_DONE_I), .VEC_ACK_I(VEC_ACK_I), .FETCH_O(FETCH_O),
    .STACK_PUSH_O(STACK_PUSH_O), .STACK_PULL_O(STACK_PULL_O),
    .PC_LOAD_VALID_O(PC_LOAD_VALID_O), .CPU_CLK_EN_O(CPU_CLK_EN_O), .OSC_EN_O(OSC_EN_O),
    .IMASK_O(IMASK_O));

/* testbench/tb.sv */
// Self-checking bench for the interrupt sequencer.
// Assumes the core model answers stacking and vector fetches.
`timescale 1ns/1ps
`include "mis_consts.svh"
module tb;
    import mis_pkg::*;
    localparam logic [1:0] OK = `MIS_RESP_OKAY;
    localparam logic [1:0] ERR = `MIS_RESP_SLVERR;
    logic clk, rstn, ext, wdog, slow, sdone, vack, push, pull, pcv, cpuen, oscen, imask, lvl;
    logic [2:0] tmr;
    logic [4:0] sci;
    logic [7:0] vdata, awaddr, araddr;
    logic [15:0] pc;
    logic [31:0] wdata, rdata, bitv, full;
    logic [1:0] bresp, rresp;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [7:0] a;
    mis_core_ev_t cev;
    mis_fetch_t fetch;
    int checks, miscompares, seed;

    mis_seq dut (.MCLK_I(clk), .RSTN_I(rstn), .EXT_IRQ_I(ext), .EXT_LEVEL_I(lvl),
        .TMR_FLAGS_I(tmr), .SCI_FLAGS_I(sci), .WDOG_RST_EV_I(wdog), .CORE_EV_I(cev),
        .STACK_DONE_I(sdone), .VEC_DATA_I(vdata), .VEC_ACK_I(vack), .FETCH_O(fetch),
        .STACK_PUSH_O(push), .STACK_PULL_O(pull), .PC_LOAD_O(pc), .PC_LOAD_VALID_O(pcv),
        .CPU_CLK_EN_O(cpuen), .OSC_EN_O(oscen), .IMASK_O(imask), .S_AXI_AWADDR(awaddr),
        .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
        .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
    mis_core_model u_core (.clk_i(clk), .rst_n_i(rstn), .slow_i(slow), .fetch_i(fetch),
        .push_i(push), .pull_i(pull), .done_o(sdone), .data_o(vdata), .ack_o(vack));

    // Clock, 4 ns period
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Expected program counter from a vector pair, high byte at even place
    function automatic logic [15:0] pcx(input logic [15:0] v);
        return {v[7:0] ^ 8'h5a, (v[7:0] | 8'h01) ^ 8'h5a};
    endfunction

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        checks++;
        if (s !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic wrap_up;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Write: address and data offered together, each dropped when taken
    task automatic wr(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] er);
        int n;
        @(posedge clk);
        awaddr <= ad;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 100);
        bready <= 1'b0;
        chk("bvalid", 1, bvalid);
        chk("bresp", er, bresp);
    endtask

    task automatic rd(input logic [7:0] ad, input logic [1:0] er, input logic [31:0] ed,
                      input logic [31:0] m);
        int n;
        @(posedge clk);
        araddr <= ad;
        arvalid <= 1'b1;
        rready <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 100);
        rready <= 1'b0;
        chk("rvalid", 1, rvalid);
        chk("rresp", er, rresp);
        chk("rdata", ed, rdata & m);
    endtask

    // Core event pulse: 4 done, 3 swi, 2 rti, 1 wait, 0 stop
    task automatic ev(input int k);
        @(posedge clk);
        cev <= mis_core_ev_t'(5'h01 << k);
        @(posedge clk);
        cev <= '0;
        repeat (2) @(posedge clk);
    endtask

    task automatic pin;
        @(posedge clk);
        ext <= 1'b1;
        repeat (2) @(posedge clk);
        ext <= 1'b0;
    endtask
    task automatic expv(input logic [15:0] v);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pcv !== 1'b1 && n < 300);
        chk("pc", pcx(v), pc);
        chk("mask", 1, imask);
    endtask

    // No entry sequence may start in this span
    task automatic quiet(input int n);
        int b;
        b = 0;
        repeat (n) begin
            @(posedge clk);
            if (pcv !== 1'b0 || push !== 1'b0) b++;
        end
        chk("quiet", 0, b);
    endtask
    initial begin
        seed = 32'he3ba;
        {rstn, ext, wdog, slow, tmr, sci, cev, lvl} = '0;
        {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        expv(`MIS_VEC_RESET);
        @(posedge clk);
        wdog <= 1'b1;
        @(posedge clk);
        wdog <= 1'b0;
        rd(`MIS_OFF_WDOG, OK, 32'h10, 32'h10);
        rd(`MIS_OFF_WDOG, OK, 32'h0, 32'h10);
        rd(8'h40, ERR, 32'h0, 32'hffffffff);
        wr(8'h40, 32'h0, ERR);
        $display("TEST reset and registers done");
        // Every flag: enable off, mask set, then taken at a boundary
        for (int i = 0; i < 8; i++) begin
            a = (i < 3) ? `MIS_OFF_TCR : `MIS_OFF_SCR2;
            bitv = (i < 3) ? 32'h1 << i : 32'h1 << (i - 3);
            full = (i < 3) ? 32'h7 : 32'h1f;
            slow <= 1'($random(seed));
            tmr <= (i < 3) ? bitv[2:0] : 3'h0;
            sci <= (i < 3) ? 5'h0 : bitv[4:0];
            wr(a, full ^ bitv, OK);
            wr(`MIS_OFF_CTRL, 32'h0, OK);
            ev(4);
            quiet(20);
            wr(`MIS_OFF_CTRL, 32'h1, OK);
            wr(a, bitv, OK);
            ev(4);
            quiet(20);
            wr(`MIS_OFF_CTRL, 32'h0, OK);
            quiet(4 + ($random(seed) & 7));
            ev(4);
            expv((i < 3) ? `MIS_VEC_TMR : `MIS_VEC_SCI);
            tmr <= 3'h0;
            sci <= 5'h0;
            wr(a, 32'h0, OK);
        end
        $display("TEST flags done");
        tmr <= 3'h1;
        wr(`MIS_OFF_TCR, 32'h1, OK);
        pin();
        wr(`MIS_OFF_CTRL, 32'h0, OK);
        ev(4);
        expv(`MIS_VEC_EXT);
        ev(2);
        wr(`MIS_OFF_CTRL, 32'h0, OK);
        ev(4);
        expv(`MIS_VEC_TMR);
        tmr <= 3'h0;
        wr(`MIS_OFF_CTRL, 32'h0, OK);
        ev(4);
        quiet(20);
        wr(`MIS_OFF_CTRL, 32'h1, OK);
        ev(3);
        ev(4);
        expv(`MIS_VEC_SWI);
        $display("TEST priority done");
        wr(`MIS_OFF_TCR, 32'h7, OK);
        ev(0);
        chk("osc", 0, oscen);
        chk("mask", 0, imask);
        rd(`MIS_OFF_TCR, OK, 32'h0, 32'h7);
        lvl <= 1'b1;
        tmr <= 3'h1;
        quiet(10);
        pin();
        expv(`MIS_VEC_EXT);
        chk("osc", 1, oscen);
        tmr <= 3'h0;
        wr(`MIS_OFF_SCR2, 32'h4, OK);
        ev(1);
        chk("cpuclk", 0, cpuen);
        sci <= 5'h04;
        expv(`MIS_VEC_SCI);
        chk("cpuclk", 1, cpuen);
        $display("TEST low power done");
        wrap_up();
    end

    // Hang guard, far beyond the expected run
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        wrap_up();
    end
endmodule // tb
